/* File: hw/sixpwm_pkg.sv */
// Constants shared by the six-channel pulse-width modulator
package sixpwm_pkg;
    localparam int NUM_CH = 6;
    localparam int CNT_W = 16;
    localparam int IDX_W = 3;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam int CLK_HZ = 25_000_000;
    localparam int LP_TICK_HZ = 32_000;
    localparam int FAST_HI_HZ = 24_000_000;
    localparam int FAST_LO_HZ = 1_000_000;
    // Fractional accumulator step per core clock; tick when it overflows CLK_HZ
    localparam logic [31:0] LP_STEP = 32'(LP_TICK_HZ);
    localparam logic [31:0] HI_STEP = 32'(FAST_HI_HZ);
    localparam logic [31:0] LO_STEP = 32'(FAST_LO_HZ);
    localparam logic [31:0] ACC_MOD = 32'(CLK_HZ);
    localparam logic SRC_LP = 1'b0;
    localparam logic SRC_FAST = 1'b1;
    typedef enum logic [1:0] {
        SIXPWM_IDLE = 2'b01,
        SIXPWM_RUN = 2'b10
    } sixpwm_state_t;
endpackage : sixpwm_pkg

/* File: hw/sixpwm_top.sv */
// Six-channel pulse-width modulator with per-channel tick source
`timescale 1ns/1ps
`default_nettype none
module sixpwm_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Auxiliary clock control
    input wire logic aux_clock_second_en_i,
    input wire logic aux_fast_24m_i,
    // Channel command port
    input wire logic start_i,
    input wire logic change_i,
    input wire logic stop_i,
    input wire logic [2:0] chan_idx_i,
    input wire logic src_sel_i,
    input wire logic [15:0] toggle_cnt_i,
    input wire logic [15:0] init_cnt_i,
    input wire logic invert_i,
    // Outputs and status
    output logic [5:0] pwm_o,
    output logic [5:0] pin_router_en_o,
    output logic [5:0] running_o,
    output logic cmd_error_o
);
    // Tick dividers and per-channel state
    typedef struct packed {
        logic [31:0] lp_acc;
        logic [31:0] fast_acc;
        logic lp_tick;
        logic fast_tick;
        logic err;
        sixpwm_pkg::sixpwm_state_t [5:0] st;
        logic [5:0] src;
        logic [5:0] inv;
        logic [5:0] out;
        logic [5:0][15:0] cnt;
        logic [5:0][15:0] tog;
        logic [5:0][15:0] init;
        logic [5:0][15:0] tog_pend;
        logic [5:0][15:0] init_pend;
        logic [5:0] pend;
    } sixpwm_regs_t;

    sixpwm_regs_t cur_ff;
    sixpwm_regs_t nxt_ff;
    logic fast_ok;
    logic [31:0] fast_step;
    logic [31:0] lp_sum;
    logic [31:0] fast_sum;

    assign fast_ok = aux_clock_second_en_i;
    assign fast_step = aux_fast_24m_i ? sixpwm_pkg::HI_STEP : sixpwm_pkg::LO_STEP;
    assign lp_sum = cur_ff.lp_acc + sixpwm_pkg::LP_STEP;
    assign fast_sum = cur_ff.fast_acc + fast_step;

    // Next-state logic for dividers and channels
    always_comb
    begin
        nxt_ff = cur_ff;
        nxt_ff.err = 1'b0;
        // Fractional-N dividers make one-cycle tick enables
        if (lp_sum >= sixpwm_pkg::ACC_MOD)
        begin
            nxt_ff.lp_acc = lp_sum - sixpwm_pkg::ACC_MOD;
            nxt_ff.lp_tick = 1'b1;
        end
        else
        begin
            nxt_ff.lp_acc = lp_sum;
            nxt_ff.lp_tick = 1'b0;
        end
        if (!fast_ok)
        begin
            nxt_ff.fast_acc = 32'h0000_0000;
            nxt_ff.fast_tick = 1'b0;
        end
        else if (fast_sum >= sixpwm_pkg::ACC_MOD)
        begin
            nxt_ff.fast_acc = fast_sum - sixpwm_pkg::ACC_MOD;
            nxt_ff.fast_tick = 1'b1;
        end
        else
        begin
            nxt_ff.fast_acc = fast_sum;
            nxt_ff.fast_tick = 1'b0;
        end
        for (int i = 0; i < sixpwm_pkg::NUM_CH; i++)
        begin
            if (cur_ff.st[i] == sixpwm_pkg::SIXPWM_RUN &&
                (cur_ff.src[i] ? cur_ff.fast_tick : cur_ff.lp_tick))
            begin
                // Reload on the tick that reaches the top, so a period is top minus initial
                if (cur_ff.cnt[i] == sixpwm_pkg::CNT_MAX ||
                    cur_ff.cnt[i] + 16'h0001 == sixpwm_pkg::CNT_MAX)
                begin
                    nxt_ff.cnt[i] = cur_ff.pend[i] ? cur_ff.init_pend[i] : cur_ff.init[i];
                    nxt_ff.out[i] = cur_ff.inv[i];
                    if (cur_ff.pend[i])
                    begin
                        nxt_ff.init[i] = cur_ff.init_pend[i];
                        nxt_ff.tog[i] = cur_ff.tog_pend[i];
                        nxt_ff.pend[i] = 1'b0;
                    end
                end
                else
                begin
                    nxt_ff.cnt[i] = cur_ff.cnt[i] + 16'h0001;
                    if (cur_ff.cnt[i] + 16'h0001 == cur_ff.tog[i])
                        nxt_ff.out[i] = ~cur_ff.out[i];
                end
            end
        end
        // Commands addressed by channel index
        if ((start_i || change_i || stop_i) && chan_idx_i > 3'(sixpwm_pkg::NUM_CH - 1))
            nxt_ff.err = 1'b1;
        else if (start_i)
        begin
            if (src_sel_i == sixpwm_pkg::SRC_FAST && !fast_ok)
                nxt_ff.err = 1'b1;
            else
            begin
                nxt_ff.st[chan_idx_i] = sixpwm_pkg::SIXPWM_RUN;
                nxt_ff.src[chan_idx_i] = src_sel_i;
                nxt_ff.tog[chan_idx_i] = toggle_cnt_i;
                nxt_ff.init[chan_idx_i] = init_cnt_i;
                nxt_ff.cnt[chan_idx_i] = init_cnt_i;
                nxt_ff.inv[chan_idx_i] = invert_i;
                nxt_ff.out[chan_idx_i] = invert_i;
                nxt_ff.pend[chan_idx_i] = 1'b0;
            end
        end
        else if (change_i)
        begin
            nxt_ff.tog_pend[chan_idx_i] = toggle_cnt_i;
            nxt_ff.init_pend[chan_idx_i] = init_cnt_i;
            nxt_ff.pend[chan_idx_i] = 1'b1;
        end
        else if (stop_i)
        begin
            nxt_ff.st[chan_idx_i] = sixpwm_pkg::SIXPWM_IDLE;
            nxt_ff.out[chan_idx_i] = cur_ff.inv[chan_idx_i];
        end
    end

    // State register
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cur_ff <= '0;
            for (int i = 0; i < sixpwm_pkg::NUM_CH; i++)
                cur_ff.st[i] <= sixpwm_pkg::SIXPWM_IDLE;
        end
        else
            cur_ff <= nxt_ff;
    end

    // Per-channel outputs
    generate
        for (genvar g = 0; g < sixpwm_pkg::NUM_CH; g++)
        begin : g_ch
            assign running_o[g] = (cur_ff.st[g] == sixpwm_pkg::SIXPWM_RUN);
            assign pin_router_en_o[g] = running_o[g];
        end
    endgenerate
    assign pwm_o = cur_ff.out;
    assign cmd_error_o = cur_ff.err;

    // Checks on start, wrap, toggle, tick rates and command refusal
    chk_start_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
        start_i && chan_idx_i == 3'h0 && !src_sel_i |=> pwm_o[0] == $past(invert_i))
        else $error("start level wrong");
    chk_start_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
        start_i && chan_idx_i == 3'h0 && !src_sel_i |=> cur_ff.cnt[0] == $past(init_cnt_i))
        else $error("initial count not loaded");
    chk_wrap_reload: assert property (@(posedge core_clk_i) disable iff (rst_i)
        running_o[0] && !start_i && !stop_i
        && cur_ff.cnt[0] + 16'h0001 == sixpwm_pkg::CNT_MAX
        && (cur_ff.src[0] ? cur_ff.fast_tick : cur_ff.lp_tick) |=> pwm_o[0] == cur_ff.inv[0])
        else $error("wrap did not restore level");
    chk_toggle_flip: assert property (@(posedge core_clk_i) disable iff (rst_i)
        running_o[0] && !start_i && !stop_i && cur_ff.cnt[0] + 16'h0001 == cur_ff.tog[0]
        && cur_ff.cnt[0] < sixpwm_pkg::CNT_MAX - 16'h0001
        && (cur_ff.src[0] ? cur_ff.fast_tick : cur_ff.lp_tick) |=> pwm_o[0] != $past(pwm_o[0]))
        else $error("toggle match did not invert");
    chk_idle_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !running_o[1] && !start_i |=> $stable(cur_ff.cnt[1]))
        else $error("idle counter moved");
    chk_stop_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
        stop_i && !start_i && !change_i && chan_idx_i == 3'h1
        |=> !running_o[1] && pwm_o[1] == cur_ff.inv[1])
        else $error("stop did not restore level");
    chk_bad_index: assert property (@(posedge core_clk_i) disable iff (rst_i)
        start_i && chan_idx_i > 3'h5 |=> cmd_error_o && $stable(running_o))
        else $error("bad index accepted");
    chk_fast_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !aux_clock_second_en_i |=> !cur_ff.fast_tick)
        else $error("fast tick without aux clock");
    chk_fast_24m: assert property (@(posedge core_clk_i) disable iff (rst_i)
        aux_clock_second_en_i && aux_fast_24m_i && !cur_ff.fast_tick && !$past(rst_i)
        && $past(aux_clock_second_en_i && aux_fast_24m_i) |=> cur_ff.fast_tick)
        else $error("fast tick missing at high rate");
    chk_fast_1m: assert property (@(posedge core_clk_i) disable iff (rst_i)
        aux_clock_second_en_i && !aux_fast_24m_i && cur_ff.fast_tick && !$past(rst_i)
        && $past(aux_clock_second_en_i && !aux_fast_24m_i) |=> !cur_ff.fast_tick)
        else $error("fast ticks too close at low rate");
    chk_lp_spacing: assert property (@(posedge core_clk_i) disable iff (rst_i)
        cur_ff.lp_tick |=> !cur_ff.lp_tick [*8])
        else $error("low-power ticks too close");
    chk_start_run: assert property (@(posedge core_clk_i) disable iff (rst_i)
        start_i && chan_idx_i == 3'h2 && !src_sel_i |=> running_o[2] && pin_router_en_o[2])
        else $error("start did not run channel");
    chk_change_live: assert property (@(posedge core_clk_i) disable iff (rst_i)
        change_i && !start_i && !stop_i && chan_idx_i == 3'h0 && running_o[0]
        |=> running_o[0] && cur_ff.pend[0])
        else $error("change stopped channel");
    cov_start: cover property (@(posedge core_clk_i) start_i && chan_idx_i == 3'h0);
    cov_toggle: cover property (@(posedge core_clk_i) running_o[0] && $changed(pwm_o[0]));
    cov_change: cover property (@(posedge core_clk_i) change_i && running_o[0]);
    cov_fast: cover property (@(posedge core_clk_i) running_o[3] && cur_ff.src[3]);
endmodule : sixpwm_top
`default_nettype wire

/* File: tb/sixpwm_pins.sv */
// Pad model: router drives pads while enabled, pull-downs otherwise
`timescale 1ns/1ps
`default_nettype none
module sixpwm_pins (
    // Channel side
    input wire logic [5:0] pwm_i,
    input wire logic [5:0] route_en_i,
    // Pad side
    output logic [5:0] pad_o
);
    // Pads not routed as outputs fall to the pull-down level
    assign pad_o = pwm_i & route_en_i;
endmodule : sixpwm_pins
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the six-channel pulse-width modulator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic aux_en = 1'h0;
    logic f24 = 1'h0;
    logic src = 1'h0;
    logic inv = 1'h0;
    logic [2:0] go = 3'h0;
    logic [2:0] idx = 3'h0;
    logic [15:0] tog = 16'h0000;
    logic [15:0] ini = 16'h0000;
    logic [31:0] r = 32'h5d72_b49a;
    wire logic [5:0] pwm, en, run, pin;
    wire logic err;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int n, m;
    sixpwm_top i_sixpwm_top (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .aux_clock_second_en_i(aux_en), .aux_fast_24m_i(f24), .start_i(go[0]),
        .change_i(go[1]), .stop_i(go[2]), .chan_idx_i(idx), .src_sel_i(src),
        .toggle_cnt_i(tog), .init_cnt_i(ini), .invert_i(inv), .pwm_o(pwm),
        .pin_router_en_o(en), .running_o(run), .cmd_error_o(err));
    sixpwm_pins i_sixpwm_pins (.pwm_i(pwm), .route_en_i(en), .pad_o(pin));
    // Clock and cycle ceiling
    always #20 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 95000)
        begin
            bad_count++;
            stop_test();
        end
    end
    // Repeatable xorshift source
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // Clock cycles per tick, shortest or longest, for a source
    function automatic int tk(input logic s, input logic f, input logic hi);
        return !s ? (hi ? 782 : 781) : f ? (hi ? 2 : 1) : 25;
    endfunction : tk
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic stop_test();
        $display("Mismatches %0d, compared %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    // One command pulse; returns half a cycle after it is taken
    task automatic cmd(input logic [2:0] k);
        @(negedge core_clk_i) go = k;
        @(negedge core_clk_i) go = 3'h0;
    endtask : cmd
    // Wait for the pad to reach a level after t ticks, within tick bounds
    task automatic lvl(input logic v, input int t);
        int c;
        c = 0;
        while (pin[idx] !== v && c < t * tk(src, f24, 1) + 2)
        begin
            @(negedge core_clk_i);
            c++;
        end
        chk("edge_time", 16'h1, 16'(pin[idx] === v && c >= (t - 1) * tk(src, f24, 0) - 1));
    endtask : lvl
    // Refusals first, then random channels with tight counts
    initial
    begin
        repeat (6) @(posedge core_clk_i);
        @(negedge core_clk_i) rst_i = 1'h0;
        chk("pwm_reset", 16'h0, 16'(pwm));
        idx = 3'h6;
        cmd(3'h1);
        chk("err_index", 16'h1, 16'(err));
        idx = 3'h0;
        src = 1'h1;
        cmd(3'h1);
        chk("err_aux_off", 16'h1, 16'(err));
        chk("run_aux_off", 16'h0, 16'(run));
        aux_en = 1'h1;
        repeat (6)
        begin
            r = xs(r);
            idx = 3'(r[7:0] % 6);
            {f24, inv, src} = r[10:8];
            // Low-power ticks are slow: their counts stay short to fit the run
            n = 2 + int'(r[12:11] & {src, 1'b1});
            m = 2 + int'(r[14:13] & {src, 1'b1});
            ini = 16'hFFFF - 16'(n + m);
            tog = 16'hFFFF - 16'(m);
            cmd(3'h1);
            chk("run_start", 16'h1, 16'(run[idx]));
            chk("pad_start", 16'(inv), 16'(pin[idx]));
            lvl(!inv, n);
            lvl(inv, m);
            tog = 16'hFFFF - 16'(n);
            cmd(3'h2);
            lvl(!inv, n);
            lvl(inv, m);
            lvl(!inv, m);
            cmd(3'h4);
            chk("run_stop", 16'h0, 16'(run[idx]));
            chk("pwm_stop", 16'(inv), 16'(pwm[idx]));
        end
        // Reset in mid-run drops a running channel
        cmd(3'h1);
        chk("run_restart", 16'h1, 16'(run[idx]));
        rst_i = 1'h1;
        @(negedge core_clk_i) rst_i = 1'h0;
        chk("run_after_reset", 16'h0, 16'(run));
        chk("pwm_after_reset", 16'h0, 16'(pwm));
        stop_test();
    end
endmodule : testbench
`default_nettype wire
